/* File: port_statistics.sv */
`timescale 1ns/10ps
`default_nettype none
module port_statistics
#(
	parameter int unsigned JABBER_LOCKUP_TIMER = stats_pkg::JABBER_LOCKUP_BITS
)
(
	input  wire logic                            pclk,                 // 200 MHz clock
	input  wire logic                            presetn,              // async reset, low
	input  wire logic                            psel,                 // apb select
	input  wire logic                            penable,              // apb access phase
	input  wire logic                            pwrite,               // apb write
	input  wire logic [7:0]                      paddr,                // apb byte address
	input  wire logic [31:0]                     pwdata,               // apb write data
	output logic      [31:0]                     prdata,               // apb read data
	output logic                                 pready,               // apb ready
	output logic                                 pslverr,              // apb error
	input  wire logic                            port_carrier,         // carrier on this port
	input  wire logic                            net_carrier,          // carrier on any port
	input  wire logic                            collision_seen,       // collision on this port
	input  wire logic                            collision_input_sqe,  // collision input is sqe
	input  wire logic                            frame_done,           // pulse: frame received
	input  wire logic [stats_pkg::OCTET_W-1:0]   octet_tally,          // octets of that frame
	input  wire logic                            check_sequence_fault, // frame fcs bad
	input  wire logic                            framing_fault,        // frame not octet aligned
	input  wire logic                            sqe_test_seen,        // pulse: sqe test message
	output logic                                 sqe_detected,         // sticky sqe test seen
	output logic      [1:0]                      sqe_action            // action being taken
);
	localparam logic [stats_pkg::LEN_W-1:0] JABBER_LIMIT = stats_pkg::LEN_W'(JABBER_LOCKUP_TIMER);

	// ---- activity measurement on this port
	wire [stats_pkg::LEN_W-1:0] activity_length;
	wire                        port_end;

	activity_timer u_timer
	(
		.pclk            (pclk),
		.presetn         (presetn),
		.active          (port_carrier),
		.activity_length (activity_length),
		.episode_end     (port_end)
	);

	// ---- per-episode flags
	logic net_carrier_q;
	logic net_coll_flag;
	logic port_coll_flag;
	logic late_flag;
	logic sqe_q;

	wire net_end   = net_carrier_q && !net_carrier;
	wire net_start = net_carrier && !net_carrier_q;
	wire sqe_rise  = collision_input_sqe && !sqe_q;
	wire late_hit  = port_carrier && sqe_rise && (activity_length > stats_pkg::LATE_EVENT_LIMIT);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			net_carrier_q <= 1'b0;
			sqe_q         <= 1'b0;
		end
		else
		begin
			net_carrier_q <= net_carrier;
			sqe_q         <= collision_input_sqe;
		end
	end

	// collision during any network episode; a late hit counts as one too
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			net_coll_flag <= 1'b0;
		else if (net_start || net_end)
			net_coll_flag <= net_start && collision_seen;
		else if (net_carrier && (collision_seen || late_hit))
			net_coll_flag <= 1'b1;
	end

	// late flag lives for one port episode; cleared after its end is counted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			late_flag <= 1'b0;
		else if (late_hit)
			late_flag <= 1'b1;
		else if (port_end)
			late_flag <= 1'b0;
	end

	// collision seen while this port carried a frame
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_coll_flag <= 1'b0;
		else if (port_carrier && collision_seen)
			port_coll_flag <= 1'b1;
		else if (frame_done && !port_carrier)
			port_coll_flag <= 1'b0;
	end

	// ---- frame classification
	wire frame_coll = port_coll_flag || collision_seen;
	wire in_range   = (octet_tally >= stats_pkg::FRAME_SIZE_FLOOR) &&
	                  (octet_tally <= stats_pkg::FRAME_SIZE_CEILING);
	wire too_long   = octet_tally > stats_pkg::FRAME_SIZE_CEILING;

	wire readable   = frame_done && in_range && !check_sequence_fault && !frame_coll;
	wire fcs_err    = frame_done && in_range && check_sequence_fault && !framing_fault && !frame_coll;
	wire align_err  = frame_done && in_range && check_sequence_fault && framing_fault && !frame_coll;
	wire oversize   = frame_done && too_long;

	// ---- episode classification, evaluated on the carrier drop
	wire short_ev   = port_end && (activity_length < stats_pkg::SHORT_EVENT_LIMIT);
	wire late_ev    = port_end && (late_flag || late_hit);
	wire very_long  = port_end && (activity_length > JABBER_LIMIT);
	// a late hit on the very drop edge must still reach the collision count
	wire coll_ev    = net_end && (net_coll_flag || collision_seen || late_hit);

	// ---- counters
	wire [stats_pkg::NUM_CNT-1:0]  cnt_inc;
	wire [stats_pkg::OCTET_W-1:0]  cnt_amt [stats_pkg::NUM_CNT];
	wire [stats_pkg::CNT_W-1:0]    cnt_val [stats_pkg::NUM_CNT];

	assign cnt_inc[stats_pkg::IDX_READABLE]  = readable;
	assign cnt_inc[stats_pkg::IDX_OCTETS]    = readable;
	assign cnt_inc[stats_pkg::IDX_COLLISION] = coll_ev;
	assign cnt_inc[stats_pkg::IDX_FCS_ERR]   = fcs_err;
	assign cnt_inc[stats_pkg::IDX_ALIGN_ERR] = align_err;
	assign cnt_inc[stats_pkg::IDX_TOO_LONG]  = oversize;
	assign cnt_inc[stats_pkg::IDX_SHORT]     = short_ev;
	assign cnt_inc[stats_pkg::IDX_LATE]      = late_ev;
	assign cnt_inc[stats_pkg::IDX_VERY_LONG] = very_long;

	genvar g;
	generate
		for (g = 0; g < stats_pkg::NUM_CNT; g++)
		begin : g_cnt
			// only the octet counter adds the tally, the rest count by one
			assign cnt_amt[g] = (g == stats_pkg::IDX_OCTETS) ? octet_tally : 16'h0001;
			stat_counter u_cnt
			(
				.pclk    (pclk),
				.presetn (presetn),
				.inc     (cnt_inc[g]),
				.amount  (cnt_amt[g]),
				.count   (cnt_val[g])
			);
		end
	endgenerate

	// ---- sqe test reporting
	logic sqe_live;
	logic [1:0] sqe_live_cnt;

	// live stays up until the fourth network episode end after the last message; cheap stretch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sqe_live     <= 1'b0;
			sqe_live_cnt <= 2'h0;
		end
		else if (sqe_test_seen)
		begin
			sqe_live     <= 1'b1;
			sqe_live_cnt <= 2'h3;
		end
		else if (net_end)
		begin
			if (sqe_live_cnt == 2'h0)
				sqe_live <= 1'b0;
			else
				sqe_live_cnt <= sqe_live_cnt - 2'h1;
		end
	end

	// ---- apb slave
	stats_pkg::apb_state_t state;
	stats_pkg::apb_state_t next_state;

	function automatic logic [3:0] counter_index(input logic [7:0] addr);
		counter_index = addr[5:2];
	endfunction

	function automatic logic is_counter(input logic [7:0] addr);
		is_counter = (addr[1:0] == 2'h0) && (addr <= stats_pkg::OFS_VERY_LONG);
	endfunction

	wire        access     = psel && penable && (state == stats_pkg::APB_WAIT);
	wire        hit_cnt    = is_counter(paddr);
	wire        hit_status = paddr == stats_pkg::OFS_SQE_STATUS;
	wire        hit_ctrl   = paddr == stats_pkg::OFS_CONTROL;
	wire        mapped     = hit_cnt || hit_status || hit_ctrl;
	wire        wr_status  = access && pwrite && hit_status;
	wire        wr_ctrl    = access && pwrite && hit_ctrl;
	// counters are read only: a write there is refused with an error
	wire        bad_access = !mapped || (pwrite && hit_cnt);

	wire [31:0] status_word = {28'h0000000, sqe_action, sqe_live, sqe_detected};
	wire [31:0] ctrl_word   = {30'h00000000, sqe_action};
	wire [31:0] cnt_word    = hit_cnt ? cnt_val[counter_index(paddr)] : 32'h00000000;
	wire [31:0] read_word   = hit_cnt    ? cnt_word :
	                          hit_status ? status_word :
	                          hit_ctrl   ? ctrl_word : 32'h00000000;

	always_comb
	begin
		next_state = state;
		case (state)
			stats_pkg::APB_IDLE:
				if (psel && !penable)
					next_state = stats_pkg::APB_WAIT;
			stats_pkg::APB_WAIT:
				if (psel && penable)
					next_state = stats_pkg::APB_DONE;
			stats_pkg::APB_DONE:
				next_state = (psel && !penable) ? stats_pkg::APB_WAIT : stats_pkg::APB_IDLE;
			default:
				next_state = stats_pkg::APB_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= stats_pkg::APB_IDLE;
		else
			state <= next_state;
	end

	// one wait state: the whole word is captured at one edge so an
	// increment in the same cycle cannot tear it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= access;
			pslverr <= access && bad_access;
			if (access && !pwrite && !bad_access)
				prdata <= read_word;
			else
				prdata <= 32'h00000000;
		end
	end

	// sticky detect: write one clears, a new message in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sqe_detected <= 1'b0;
		else if (sqe_test_seen)
			sqe_detected <= 1'b1;
		else if (wr_status && pwdata[stats_pkg::SQE_DET_BIT])
			sqe_detected <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sqe_action <= stats_pkg::SQE_ACT_RESET;
		else if (wr_ctrl)
			sqe_action <= pwdata[stats_pkg::CTRL_ACT_LSB +: 2];
	end
endmodule
`default_nettype wire

/* File: stats_pkg.sv */
package stats_pkg;
	localparam int unsigned CNT_W         = 32;
	localparam int unsigned OCTET_W       = 16;
	localparam int unsigned LEN_W         = 16;
	localparam int unsigned NUM_CNT       = 9;

	// register byte offsets
	localparam logic [7:0] OFS_READABLE   = 8'h00;
	localparam logic [7:0] OFS_OCTETS     = 8'h04;
	localparam logic [7:0] OFS_COLLISION  = 8'h08;
	localparam logic [7:0] OFS_FCS_ERR    = 8'h0c;
	localparam logic [7:0] OFS_ALIGN_ERR  = 8'h10;
	localparam logic [7:0] OFS_TOO_LONG   = 8'h14;
	localparam logic [7:0] OFS_SHORT      = 8'h18;
	localparam logic [7:0] OFS_LATE       = 8'h1c;
	localparam logic [7:0] OFS_VERY_LONG  = 8'h20;
	localparam logic [7:0] OFS_SQE_STATUS = 8'h24;
	localparam logic [7:0] OFS_CONTROL    = 8'h28;

	// sqe status / control fields
	localparam int unsigned SQE_DET_BIT   = 0;
	localparam int unsigned SQE_LIVE_BIT  = 1;
	localparam int unsigned SQE_ACT_LSB   = 2;
	localparam int unsigned CTRL_ACT_LSB  = 0;
	localparam logic [1:0] SQE_ACT_RESET  = 2'h0;

	// counter indices
	localparam int unsigned IDX_READABLE  = 0;
	localparam int unsigned IDX_OCTETS    = 1;
	localparam int unsigned IDX_COLLISION = 2;
	localparam int unsigned IDX_FCS_ERR   = 3;
	localparam int unsigned IDX_ALIGN_ERR = 4;
	localparam int unsigned IDX_TOO_LONG  = 5;
	localparam int unsigned IDX_SHORT     = 6;
	localparam int unsigned IDX_LATE      = 7;
	localparam int unsigned IDX_VERY_LONG = 8;

	// frame sizes in octets
	localparam logic [OCTET_W-1:0] FRAME_SIZE_FLOOR   = 16'h0040;
	localparam logic [OCTET_W-1:0] FRAME_SIZE_CEILING = 16'h05ee;

	// timing
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned BIT_TIME_NS   = 100;
	localparam int unsigned BIT_CYCLES    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [LEN_W-1:0] SHORT_EVENT_LIMIT   = 16'h004c;
	localparam logic [LEN_W-1:0] LATE_EVENT_LIMIT    = 16'h01e0;
	localparam int unsigned JABBER_LOCKUP_BITS       = 50000;

	typedef enum logic [1:0] {
		APB_IDLE,
		APB_WAIT,
		APB_DONE
	} apb_state_t;
endpackage

/* File: stat_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module stat_counter
(
	input  wire logic                           pclk,    // clock
	input  wire logic                           presetn, // async reset, low
	input  wire logic                           inc,     // add amount this cycle
	input  wire logic [stats_pkg::OCTET_W-1:0]  amount,  // value to add
	output logic      [stats_pkg::CNT_W-1:0]    count    // running total
);
	// wraps past all ones by plain modular add; a count by one wraps to zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= '0;
		else if (inc)
			count <= count + {{(stats_pkg::CNT_W-stats_pkg::OCTET_W){1'b0}}, amount};
	end
endmodule
`default_nettype wire

/* File: activity_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module activity_timer
(
	input  wire logic                         pclk,            // clock
	input  wire logic                         presetn,         // async reset, low
	input  wire logic                         active,          // carrier present
	output logic      [stats_pkg::LEN_W-1:0]  activity_length, // bit times so far
	output logic                              episode_end      // pulse on carrier drop
);
	localparam int unsigned DIV_W = $clog2(stats_pkg::BIT_CYCLES);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(stats_pkg::BIT_CYCLES - 1);

	logic [DIV_W-1:0] div;
	logic             active_q;
	wire              bit_tick = active && (div == DIV_LAST);
	wire              len_full = &activity_length;

	// divider restarts each episode so length is measured from carrier start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div             <= '0;
			active_q        <= 1'b0;
			activity_length <= '0;
			episode_end     <= 1'b0;
		end
		else
		begin
			active_q    <= active;
			episode_end <= active_q && !active;
			if (!active)
				div <= '0;
			else if (bit_tick)
				div <= '0;
			else
				div <= div + 1'b1;
			// length holds after the drop so the end can be classified
			if (active && !active_q)
				activity_length <= '0;
			else if (bit_tick && !len_full)
				activity_length <= activity_length + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: port_statistics_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module port_statistics_asserts
(
	input wire logic        pclk,          // clock
	input wire logic        presetn,       // async reset, low
	input wire logic        psel,          // apb select
	input wire logic        penable,       // apb access
	input wire logic        pwrite,        // apb write
	input wire logic [7:0]  paddr,         // apb address
	input wire logic [31:0] pwdata,        // apb write data
	input wire logic [31:0] prdata,        // apb read data
	input wire logic        pready,        // apb ready
	input wire logic        pslverr,       // apb error
	input wire logic        sqe_test_seen, // sqe message pulse
	input wire logic        sqe_detected,  // sticky sqe flag
	input wire logic [1:0]  sqe_action     // sqe action
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// first access cycle only, so back-to-back transfers are not seen twice
	wire logic open_access = psel && penable && !pready;
	property p_ready_wait; open_access |=> pready; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	property p_idle_rdata; !pready |-> prdata == 32'h0; endproperty
	a_idle_rdata: assert property (p_idle_rdata) else $error("prdata outside answer");
	property p_err_pulse; pslverr |-> pready; endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("pslverr without pready");
	property p_counter_ro; open_access && pwrite && paddr <= 8'h20 |=> pslverr; endproperty
	a_counter_ro: assert property (p_counter_ro) else $error("counter write accepted");
	property p_bad_align; open_access && paddr[1:0] != 2'h0 |=> pslverr; endproperty
	a_bad_align: assert property (p_bad_align) else $error("partial word accepted");
	property p_sqe_set; sqe_test_seen |=> sqe_detected; endproperty
	a_sqe_set: assert property (p_sqe_set) else $error("sqe message missed");
	property p_sqe_hold; sqe_detected && !(open_access && pwrite) |=> sqe_detected; endproperty
	a_sqe_hold: assert property (p_sqe_hold) else $error("sqe flag lost");
	property p_ctrl_write;
		open_access && pwrite && paddr == stats_pkg::OFS_CONTROL |=> sqe_action == $past(pwdata[1:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("action not written");
	property p_ctrl_hold; !(open_access && pwrite) |=> $stable(sqe_action); endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("action changed");
	c_refused: cover property (pslverr);
	c_sqe: cover property (sqe_test_seen ##1 sqe_detected);
	c_read: cover property (pready && !pwrite && prdata != 32'h0);
endmodule
bind port_statistics port_statistics_asserts u_port_statistics_asserts
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sqe_test_seen(sqe_test_seen), .sqe_detected(sqe_detected), .sqe_action(sqe_action)
);
`default_nettype wire

/* File: port_model.sv */
`timescale 1ns/10ps
`default_nettype none
module port_model
(
	input  wire logic        pclk,                 // clock
	output logic             port_carrier,         // carrier here
	output logic             net_carrier,          // carrier anywhere
	output logic             collision_seen,       // collision here
	output logic             collision_input_sqe,  // collision input sqe
	output logic             frame_done,           // frame end pulse
	output logic [15:0]      octet_tally,          // frame octets
	output logic             check_sequence_fault, // fcs bad
	output logic             framing_fault,        // misaligned
	output logic             sqe_test_seen         // sqe message pulse
);
	initial
	begin
		{port_carrier, net_carrier, collision_seen, collision_input_sqe, frame_done} = 5'h0;
		{check_sequence_fault, framing_fault} = 2'h0;
		octet_tally = 16'h0;
		sqe_test_seen = 1'b0;
	end
	// qualifiers go to the inverse once the pulse is over, collision_seen to zero, never a stale copy
	task automatic frame(input logic [15:0] o, input logic f, input logic g, input logic c);
		@(posedge pclk);
		frame_done <= 1'b1;
		octet_tally <= o;
		check_sequence_fault <= f;
		framing_fault <= g;
		collision_seen <= c;
		@(posedge pclk);
		frame_done <= 1'b0;
		octet_tally <= ~o;
		check_sequence_fault <= ~f;
		framing_fault <= ~g;
		collision_seen <= 1'b0;
	endtask
	task automatic episode(input int bits, input logic c, input int sqe_bit);
		@(posedge pclk);
		port_carrier <= 1'b1;
		net_carrier <= 1'b1;
		collision_seen <= c;
		for (int i = 1; i < bits * stats_pkg::BIT_CYCLES; i++)
		begin
			@(posedge pclk);
			if (sqe_bit != 0 && i == sqe_bit * stats_pkg::BIT_CYCLES)
				collision_input_sqe <= 1'b1;
		end
		@(posedge pclk);
		{port_carrier, net_carrier, collision_seen, collision_input_sqe} <= 4'h0;
	endtask
	// only on command: a conforming transceiver keeps this off
	task automatic sqe_pulse();
		@(posedge pclk);
		sqe_test_seen <= 1'b1;
		@(posedge pclk);
		sqe_test_seen <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, rerr, sqe_detected;
	logic [1:0]  sqe_action;
	logic        pc, nc, cs, cq, fd, fcs, ff, sq;
	logic [15:0] ot;
	logic [31:0] exp_cnt [9] = '{default: 32'h0};
	int          fails = 0;
	int          checks_done = 0;
	always #2.5 pclk = ~pclk;
	port_statistics #(.JABBER_LOCKUP_TIMER(600)) u_port_statistics
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_carrier(pc), .net_carrier(nc), .collision_seen(cs), .collision_input_sqe(cq),
		.frame_done(fd), .octet_tally(ot), .check_sequence_fault(fcs), .framing_fault(ff),
		.sqe_test_seen(sq), .sqe_detected(sqe_detected), .sqe_action(sqe_action)
	);
	port_model u_port_model
	(
		.pclk(pclk), .port_carrier(pc), .net_carrier(nc), .collision_seen(cs),
		.collision_input_sqe(cq), .frame_done(fd), .octet_tally(ot), .check_sequence_fault(fcs),
		.framing_fault(ff), .sqe_test_seen(sq)
	);
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want)
		begin
			fails++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	// request held until pready is seen high at a rising edge; answer taken at that edge
	// design outputs move by nba, so values read right after the edge are what it sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			chk(1'b0, 1'b1);
		rdat = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] want);
		apb(1'b0, a, 32'h0);
		chk(rerr, 1'b0);
		chk(rdat & mask, want);
	endtask
	task automatic check_all();
		for (int i = 0; i < 9; i++)
			rd_chk(8'(i * 4), 32'hffffffff, exp_cnt[i]);
	endtask
	task automatic t_reset();
		check_all();
		rd_chk(stats_pkg::OFS_CONTROL, 32'h3, 32'h0);
		rd_chk(stats_pkg::OFS_SQE_STATUS, 32'hf, 32'h0);
	endtask
	task automatic t_bus();
		apb(1'b1, 8'h08, 32'h5);
		chk(rerr, 1'b1);
		apb(1'b1, 8'h30, 32'h5);
		chk(rerr, 1'b1);
		apb(1'b0, 8'h02, 32'h0);
		chk(rerr, 1'b1);
		chk(rdat, 32'h0);
		apb(1'b1, stats_pkg::OFS_CONTROL, 32'h2);
		chk(sqe_action, 2'h2);
		rd_chk(stats_pkg::OFS_CONTROL, 32'h3, 32'h2);
		check_all();
	endtask
	task automatic t_sqe();
		chk(sqe_detected, 1'b0);
		u_port_model.sqe_pulse();
		@(negedge pclk);
		chk(sqe_detected, 1'b1);
		rd_chk(stats_pkg::OFS_SQE_STATUS, 32'hf, 32'hb);
		apb(1'b1, stats_pkg::OFS_SQE_STATUS, 32'h1);
		rd_chk(stats_pkg::OFS_SQE_STATUS, 32'hf, 32'ha);
		chk(sqe_detected, 1'b0);
	endtask
	task automatic t_frames();
		logic [15:0] oct [9] = '{16'd64, 16'd1518, 16'd63, 16'd1519, 16'd100, 16'd100, 16'd1519, 16'd200, 16'd100};
		logic [2:0]  flt [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h6, 3'h6, 3'h1, 3'h5};
		logic        f, g, c, inr;
		for (int i = 0; i < 9; i++)
		begin
			{f, g, c} = flt[i];
			u_port_model.frame(oct[i], f, g, c);
			inr = oct[i] >= stats_pkg::FRAME_SIZE_FLOOR && oct[i] <= stats_pkg::FRAME_SIZE_CEILING;
			if (inr && !f && !c)
			begin
				exp_cnt[0]++;
				exp_cnt[1] += 32'(oct[i]);
			end
			if (inr && f && !g && !c)
				exp_cnt[3]++;
			if (inr && f && g && !c)
				exp_cnt[4]++;
			if (oct[i] > stats_pkg::FRAME_SIZE_CEILING)
				exp_cnt[5]++;
		end
		repeat (2) @(posedge pclk);
		check_all();
	endtask
	task automatic ep(input int bits, input logic c, input int sqe_bit);
		u_port_model.episode(bits, c, sqe_bit);
		repeat (4) @(posedge pclk);
		check_all();
	endtask
	task automatic t_events();
		exp_cnt[6]++;
		ep(70, 1'b0, 0);
		ep(80, 1'b0, 0);
		exp_cnt[2]++;
		ep(100, 1'b1, 0);
		exp_cnt[2]++;
		exp_cnt[7]++;
		ep(500, 1'b0, 490);
		ep(100, 1'b0, 90);
		exp_cnt[8]++;
		ep(610, 1'b0, 0);
		// live flag lapses after four network episodes with no message
		rd_chk(stats_pkg::OFS_SQE_STATUS, 32'hf, 32'h8);
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_bus();
		t_sqe();
		t_frames();
		t_events();
		test_done();
	end
	initial
	begin
		repeat (60000) @(posedge pclk);
		fails++;
		test_done();
	end
endmodule
`default_nettype wire
